/* File: shared/ifd_params.svh */
// Constants of the instruction format decoder: field positions, lengths, opcodes.
// Assumes instructions are held as a 48-bit word, instruction bit 0 at index 47.
// Summary of operation
// - Instructions are 2, 4 or 6 bytes; pointer advances
// - Five formats, opcode byte then operand fields
// - Register-register: bits 8-11 and 12-15 are registers
// - Indexed: index 12-15, base 16-19, offset 20-31
// - Register-storage: first and last group register fields
// - Immediate byte 8-15, first address in halfword two
// - Storage-storage: one 8-bit or two 4-bit lengths
// - Encoded lengths are true length minus one
// - Register-register: double word float, word general
// - First field register or mask, second register
// - Some register-register operations use immediate data
// - Indexed: at most double word, second is storage
// - 84 basic, 64 expansion, 2 protection operations
// - Logical lengths 1-256, decimal lengths 1-16
`ifndef IFD_PARAMS_SVH
`define IFD_PARAMS_SVH
`define IFD_ADDR_W      18
`define IFD_LEN_HALF    3'h2
`define IFD_LEN_FULL    3'h4
`define IFD_LEN_LONG    3'h6
`define IFD_HW_ONE      2'h1
`define IFD_HW_TWO      2'h2
`define IFD_HW_THREE    2'h3
`define IFD_OPC_LSB     40
`define IFD_R1_LSB      36
`define IFD_R2_LSB      32
`define IFD_B1_LSB      28
`define IFD_D1_LSB      16
`define IFD_B2_LSB      12
`define IFD_D2_LSB      0
`define IFD_RR_MASK_OP  8'h07
`define IFD_RR_IMM_OP   8'h0A
`define IFD_RX_MASK_OP  8'h47
`define IFD_SS_DEC_ROW  4'hF
`endif

/* File: shared/ifd_pkg.sv */
// Types of the instruction format decoder: formats, sizes, states, state record.
// Assumes ifd_params.svh sets the address width.
`default_nettype none
`include "ifd_params.svh"
package ifd_pkg;
    typedef enum logic [2:0] {
        IFD_FMT_RR = 3'h0,
        IFD_FMT_RX = 3'h1,
        IFD_FMT_RS = 3'h2,
        IFD_FMT_SI = 3'h3,
        IFD_FMT_SS = 3'h4
    } ifd_fmt_t;
    typedef enum logic [2:0] {
        IFD_SZ_BYTE = 3'h0,
        IFD_SZ_HALF = 3'h1,
        IFD_SZ_WORD = 3'h2,
        IFD_SZ_DBL  = 3'h3,
        IFD_SZ_VAR  = 3'h4
    } ifd_size_t;
    typedef enum logic [2:0] {
        IFD_ST_IDLE  = 3'h0,
        IFD_ST_FETCH = 3'h1,
        IFD_ST_ADDR1 = 3'h2,
        IFD_ST_ADDR2 = 3'h3,
        IFD_ST_OFFER = 3'h4
    } ifd_state_t;
    typedef enum logic [1:0] {
        IFD_ERR_NONE = 2'h0,
        IFD_ERR_ODD  = 2'h1,
        IFD_ERR_OP   = 2'h2
    } ifd_err_t;
    typedef struct packed {
        ifd_state_t              state;
        logic [`IFD_ADDR_W-1:0]  pc;
        logic [47:0]             inst;
        logic [1:0]              hw_cnt;
        logic [1:0]              hw_tot;
        logic [`IFD_ADDR_W-1:0]  ea1;
        logic [`IFD_ADDR_W-1:0]  ea2;
        ifd_err_t                err;
    } ifd_regs_t;
endpackage
`default_nettype wire

/* File: hdl/ifd_field_extract.sv */
// Field extractor: splits a held instruction word into its format fields.
// Assumes the word is left-aligned with unused halfwords zero.
`timescale 1ns/1ps
`default_nettype none
`include "ifd_params.svh"
module ifd_field_extract (
    input  wire logic [47:0]      inst_i,
    output ifd_pkg::ifd_fmt_t     fmt_o,
    output ifd_pkg::ifd_size_t    size_o,
    output logic [2:0]            len_o,
    output logic [3:0]            r1_o,
    output logic [3:0]            r2_o,
    output logic [3:0]            x2_o,
    output logic [3:0]            b1_o,
    output logic [11:0]           d1_o,
    output logic [3:0]            b2_o,
    output logic [11:0]           d2_o,
    output logic                  mask_o,
    output logic                  imm_vld_o,
    output logic [7:0]            imm_o,
    output logic [8:0]            oplen1_o,
    output logic [8:0]            oplen2_o
);
    logic [7:0] opc;
    logic [7:0] byte2;
    always_comb begin
        opc       = inst_i[`IFD_OPC_LSB +: 8];
        byte2     = inst_i[`IFD_R2_LSB +: 8];
        r1_o      = inst_i[`IFD_R1_LSB +: 4];
        r2_o      = 4'h0;
        x2_o      = 4'h0;
        b1_o      = 4'h0;
        d1_o      = 12'h000;
        b2_o      = 4'h0;
        d2_o      = 12'h000;
        mask_o    = 1'b0;
        imm_vld_o = 1'b0;
        imm_o     = 8'h00;
        oplen1_o  = 9'h000;
        oplen2_o  = 9'h000;
        case (opc[7:6])
            2'h0: begin
                fmt_o = ifd_pkg::IFD_FMT_RR;
                len_o = `IFD_LEN_HALF;
                r2_o   = inst_i[`IFD_R2_LSB +: 4];
                mask_o = (opc == `IFD_RR_MASK_OP);
                imm_vld_o = (opc == `IFD_RR_IMM_OP);
                imm_o     = imm_vld_o ? byte2 : 8'h00;
                size_o = opc[5] ? ifd_pkg::IFD_SZ_DBL : ifd_pkg::IFD_SZ_WORD;
            end
            2'h1: begin
                fmt_o = ifd_pkg::IFD_FMT_RX;
                len_o = `IFD_LEN_FULL;
                x2_o   = inst_i[`IFD_R2_LSB +: 4];
                b2_o   = inst_i[`IFD_B1_LSB +: 4];
                d2_o   = inst_i[`IFD_D1_LSB +: 12];
                mask_o = (opc == `IFD_RX_MASK_OP);
                size_o = opc[5] ? ifd_pkg::IFD_SZ_DBL : ifd_pkg::IFD_SZ_WORD;
            end
            2'h2: begin
                len_o = `IFD_LEN_FULL;
                b2_o  = inst_i[`IFD_B1_LSB +: 4];
                d2_o  = inst_i[`IFD_D1_LSB +: 12];
                if (opc[4]) begin
                    fmt_o     = ifd_pkg::IFD_FMT_SI;
                    size_o    = ifd_pkg::IFD_SZ_BYTE;
                    r1_o      = 4'h0;
                    imm_vld_o = 1'b1;
                    imm_o     = inst_i[`IFD_R2_LSB +: 8];
                    b1_o      = b2_o;
                    d1_o      = d2_o;
                    b2_o      = 4'h0;
                    d2_o      = 12'h000;
                end else begin
                    fmt_o  = ifd_pkg::IFD_FMT_RS;
                    size_o = ifd_pkg::IFD_SZ_WORD;
                    r2_o   = inst_i[`IFD_R2_LSB +: 4];
                end
            end
            default: begin
                fmt_o  = ifd_pkg::IFD_FMT_SS;
                len_o  = `IFD_LEN_LONG;
                size_o = ifd_pkg::IFD_SZ_VAR;
                r1_o   = 4'h0;
                // two addresses, one or two lengths
                b1_o = inst_i[`IFD_B1_LSB +: 4];
                d1_o = inst_i[`IFD_D1_LSB +: 12];
                b2_o = inst_i[`IFD_B2_LSB +: 4];
                d2_o = inst_i[`IFD_D2_LSB +: 12];
                if (opc[7:4] == `IFD_SS_DEC_ROW) begin
                    oplen1_o = {5'h00, inst_i[`IFD_R1_LSB +: 4]} + 9'h001;
                    oplen2_o = {5'h00, inst_i[`IFD_R2_LSB +: 4]} + 9'h001;
                end else begin
                    oplen1_o = {1'b0, byte2} + 9'h001;
                    oplen2_o = oplen1_o;
                end
            end
        endcase
    end
endmodule
`default_nettype wire

/* File: hdl/ifd_decoder.sv */
// Instruction format decoder: fetches halfwords, decodes, forms operand addresses.
// Assumes a same-clock storage port and a combinational register file read.
`timescale 1ns/1ps
`default_nettype none
`include "ifd_params.svh"
module ifd_decoder (
    input  wire logic                   CLK_SYS_I,
    input  wire logic                   RESET_I,
    input  wire logic                   START_I,
    input  wire logic [`IFD_ADDR_W-1:0] START_ADDR_I,
    input  wire logic                   STOP_I,
    input  wire logic                   EXP_EN_I,
    input  wire logic                   PROT_EN_I,
    output logic                        MEM_REQ_O,
    output logic [`IFD_ADDR_W-1:0]      MEM_ADDR_O,
    input  wire logic                   MEM_ACK_I,
    input  wire logic [15:0]            MEM_DATA_I,
    output logic [3:0]                  REG_A_NUM_O,
    input  wire logic [31:0]            REG_A_DATA_I,
    output logic [3:0]                  REG_B_NUM_O,
    input  wire logic [31:0]            REG_B_DATA_I,
    output logic                        BUSY_O,
    output logic                        DEC_VALID_O,
    input  wire logic                   DEC_READY_I,
    output logic [1:0]                  ERR_O,
    output logic [`IFD_ADDR_W-1:0]      INST_ADDR_O,
    output logic [7:0]                  OPCODE_O,
    output logic [2:0]                  FMT_O,
    output logic [2:0]                  OP_SIZE_O,
    output logic [2:0]                  INST_LEN_O,
    output logic [3:0]                  FIRST_REG_O,
    output logic [3:0]                  SECOND_REG_O,
    output logic [3:0]                  INDEX_REG_O,
    output logic [3:0]                  FIRST_BASE_O,
    output logic [11:0]                 FIRST_OFFSET_O,
    output logic [3:0]                  SECOND_BASE_O,
    output logic [11:0]                 SECOND_OFFSET_O,
    output logic                        FIRST_IS_MASK_O,
    output logic                        IMM_VALID_O,
    output logic [7:0]                  IMM_DATA_O,
    output logic [8:0]                  OPLEN1_O,
    output logic [8:0]                  OPLEN2_O,
    output logic [`IFD_ADDR_W-1:0]      EA1_O,
    output logic [`IFD_ADDR_W-1:0]      EA2_O
);
    ifd_pkg::ifd_regs_t  r_r;
    ifd_pkg::ifd_regs_t  r_nxt;
    ifd_pkg::ifd_fmt_t   fmt;
    ifd_pkg::ifd_size_t  size;
    logic [2:0]          len;
    logic [3:0]          b1;
    logic [3:0]          b2;
    logic [3:0]          x2;
    logic [11:0]         d1;
    logic [11:0]         d2;
    logic [1:0]          tot;
    logic [`IFD_ADDR_W-1:0] base_val;
    logic [`IFD_ADDR_W-1:0] idx_val;
    logic                accept;

    // ---------------------------------------------------------------
    // Field extraction
    // ---------------------------------------------------------------
    ifd_field_extract u_extract (
        .inst_i    (r_r.inst),
        .fmt_o     (fmt),
        .size_o    (size),
        .len_o     (len),
        .r1_o      (FIRST_REG_O),
        .r2_o      (SECOND_REG_O),
        .x2_o      (x2),
        .b1_o      (b1),
        .d1_o      (d1),
        .b2_o      (b2),
        .d2_o      (d2),
        .mask_o    (FIRST_IS_MASK_O),
        .imm_vld_o (IMM_VALID_O),
        .imm_o     (IMM_DATA_O),
        .oplen1_o  (OPLEN1_O),
        .oplen2_o  (OPLEN2_O)
    );

    function automatic logic op_ok(input logic [7:0] op, input logic ex, input logic pr);
        logic b;
        logic f;
        logic x;
        logic p;
        b = (op[7:4] == 4'h1) || (op[7:4] == 4'h4) || (op[7:4] == 4'h8)
            || (op[7:4] == 4'h9) || (op[7:4] == 4'hD) || (op[7:2] == 6'h01);
        f = (op[7:4] == 4'h2) || (op[7:4] == 4'h3)
            || ((op[7:5] == 3'h3) && (op[3:0] < 4'h6));
        x = (op[7:4] == 4'hF) || ((op >= 8'h0A) && (op <= 8'h0D));
        p = (op == 8'h08) || (op == 8'h09);
        op_ok = b || (ex && (f || x)) || (pr && p);
    endfunction

    // ---------------------------------------------------------------
    // Register reads and address sums
    // ---------------------------------------------------------------
    always_comb begin
        REG_A_NUM_O = (r_r.state == ifd_pkg::IFD_ST_ADDR1) ? b1 : b2;
        REG_B_NUM_O = (r_r.state == ifd_pkg::IFD_ST_ADDR2) ? x2 : 4'h0;
        base_val = (REG_A_NUM_O == 4'h0) ? '0 : REG_A_DATA_I[`IFD_ADDR_W-1:0];
        idx_val  = (REG_B_NUM_O == 4'h0) ? '0 : REG_B_DATA_I[`IFD_ADDR_W-1:0];
    end

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    assign accept = (r_r.state == ifd_pkg::IFD_ST_OFFER) && DEC_READY_I;
    assign tot    = (MEM_DATA_I[15:14] == 2'h0) ? `IFD_HW_ONE :
                    (MEM_DATA_I[15:14] == 2'h3) ? `IFD_HW_THREE : `IFD_HW_TWO;

    always_comb begin
        r_nxt = r_r;
        case (r_r.state)
            ifd_pkg::IFD_ST_IDLE: begin
                if (START_I) begin
                    r_nxt.pc     = START_ADDR_I;
                    r_nxt.hw_cnt = 2'h0;
                    if (START_ADDR_I[0]) begin
                        r_nxt.err   = ifd_pkg::IFD_ERR_ODD;
                        r_nxt.state = ifd_pkg::IFD_ST_OFFER;
                    end else begin
                        r_nxt.state = ifd_pkg::IFD_ST_FETCH;
                    end
                end
            end
            ifd_pkg::IFD_ST_FETCH: begin
                if (MEM_ACK_I) begin
                    r_nxt.hw_cnt = r_r.hw_cnt + 2'h1;
                    case (r_r.hw_cnt)
                        2'h0: begin
                            r_nxt.inst   = {MEM_DATA_I, 32'h0000_0000};
                            r_nxt.hw_tot = tot;
                        end
                        2'h1: r_nxt.inst[31:16] = MEM_DATA_I;
                        default: r_nxt.inst[15:0] = MEM_DATA_I;
                    endcase
                    if ((r_r.hw_cnt + 2'h1) == ((r_r.hw_cnt == 2'h0) ? tot : r_r.hw_tot)) begin
                        if (!op_ok(r_nxt.inst[47:40], EXP_EN_I, PROT_EN_I)) begin
                            r_nxt.err   = ifd_pkg::IFD_ERR_OP;
                            r_nxt.state = ifd_pkg::IFD_ST_OFFER;
                        end else begin
                            r_nxt.state = ifd_pkg::IFD_ST_ADDR1;
                        end
                    end
                end
            end
            ifd_pkg::IFD_ST_ADDR1: begin
                r_nxt.ea1   = '0;
                r_nxt.ea2   = '0;
                r_nxt.state = ifd_pkg::IFD_ST_OFFER;
                if ((fmt == ifd_pkg::IFD_FMT_SI) || (fmt == ifd_pkg::IFD_FMT_SS)) begin
                    r_nxt.ea1 = base_val + {6'h00, d1};
                end
                if (fmt != ifd_pkg::IFD_FMT_RR && fmt != ifd_pkg::IFD_FMT_SI) begin
                    r_nxt.state = ifd_pkg::IFD_ST_ADDR2;
                end
            end
            ifd_pkg::IFD_ST_ADDR2: begin
                r_nxt.ea2   = base_val + idx_val + {6'h00, d2};
                r_nxt.state = ifd_pkg::IFD_ST_OFFER;
            end
            ifd_pkg::IFD_ST_OFFER: begin
                if (DEC_READY_I) begin
                    r_nxt.hw_cnt = 2'h0;
                    if ((r_r.err != ifd_pkg::IFD_ERR_NONE) || STOP_I) begin
                        r_nxt.err   = ifd_pkg::IFD_ERR_NONE;
                        r_nxt.state = ifd_pkg::IFD_ST_IDLE;
                    end else begin
                        r_nxt.pc    = r_r.pc + {15'h0000, len};
                        r_nxt.state = ifd_pkg::IFD_ST_FETCH;
                    end
                end
            end
            default: r_nxt.state = ifd_pkg::IFD_ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign MEM_REQ_O       = (r_r.state == ifd_pkg::IFD_ST_FETCH);
    assign MEM_ADDR_O      = r_r.pc + {15'h0000, r_r.hw_cnt, 1'b0};
    assign BUSY_O          = (r_r.state != ifd_pkg::IFD_ST_IDLE);
    assign DEC_VALID_O     = (r_r.state == ifd_pkg::IFD_ST_OFFER);
    assign ERR_O           = r_r.err;
    assign INST_ADDR_O     = r_r.pc;
    assign OPCODE_O        = r_r.inst[`IFD_OPC_LSB +: 8];
    assign FMT_O           = fmt;
    assign OP_SIZE_O       = size;
    assign INST_LEN_O      = len;
    assign INDEX_REG_O     = x2;
    assign FIRST_BASE_O    = b1;
    assign FIRST_OFFSET_O  = d1;
    assign SECOND_BASE_O   = b2;
    assign SECOND_OFFSET_O = d2;
    assign EA1_O           = r_r.ea1;
    assign EA2_O           = r_r.ea2;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_odd_start_err: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (r_r.state == ifd_pkg::IFD_ST_IDLE) && START_I && START_ADDR_I[0]
        |=> DEC_VALID_O && (ERR_O == 2'h1) && !MEM_REQ_O)
        else $error("odd start not flagged");
    a_pc_advance: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        accept && (ERR_O == 2'h0) && !STOP_I
        |=> (INST_ADDR_O == $past(INST_ADDR_O) + {15'h0000, $past(INST_LEN_O)}))
        else $error("pointer not advanced by length");
    a_fetch_even: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        MEM_REQ_O |-> !MEM_ADDR_O[0])
        else $error("fetch at odd address");
    a_len_format: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        DEC_VALID_O && (ERR_O == 2'h0) |-> (INST_LEN_O == ((FMT_O == 3'h0) ? 3'h2 :
        (FMT_O == 3'h4) ? 3'h6 : 3'h4)))
        else $error("length does not match format");
    a_rr_fields: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        DEC_VALID_O && (FMT_O == 3'h0)
        |-> (FIRST_REG_O == r_r.inst[39:36]) && (SECOND_REG_O == r_r.inst[35:32]))
        else $error("register fields wrong");
    a_rx_fields: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        DEC_VALID_O && (FMT_O == 3'h1) |-> (INDEX_REG_O == r_r.inst[35:32])
        && (SECOND_BASE_O == r_r.inst[31:28]) && (SECOND_OFFSET_O == r_r.inst[27:16]))
        else $error("indexed fields wrong");
    a_si_imm: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        DEC_VALID_O && (FMT_O == 3'h3) |-> IMM_VALID_O && (IMM_DATA_O == r_r.inst[39:32]))
        else $error("immediate byte wrong");
    a_ss_len_one: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        DEC_VALID_O && (FMT_O == 3'h4) && (OPCODE_O[7:4] != 4'hF)
        |-> (OPLEN1_O == {1'b0, r_r.inst[39:32]} + 9'h001) && (OPLEN2_O == OPLEN1_O))
        else $error("length not raised by one");
    a_valid_hold: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        DEC_VALID_O && !DEC_READY_I |=> DEC_VALID_O && $stable(INST_ADDR_O))
        else $error("decode dropped before taken");
    a_reg0_zero: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (r_r.state == ifd_pkg::IFD_ST_ADDR2) && (REG_A_NUM_O == 4'h0) && (REG_B_NUM_O == 4'h0)
        |=> (EA2_O == {6'h00, $past(d2)}))
        else $error("register zero added");
endmodule
`default_nettype wire

/* File: test/ifd_mem_model.sv */
// Storage and register file model facing the instruction format decoder.
// Assumes one clock; acks are registered, prompt or slow by slow_i.
`timescale 1ns/1ps
`default_nettype none
module ifd_mem_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        slow_i,
    input  wire logic        req_i,
    input  wire logic [17:0] addr_i,
    output logic             ack_o,
    output logic [15:0]      data_o,
    input  wire logic [3:0]  a_num_i,
    output logic [31:0]      a_data_o,
    input  wire logic [3:0]  b_num_i,
    output logic [31:0]      b_data_o
);
    logic [15:0] mem [64];
    logic [1:0]  wait_r;
    // ----------------------------------------
    // Register n holds n*16+8, register 0 too
    // ----------------------------------------
    assign a_data_o = {24'h0, a_num_i, 4'h8};
    assign b_data_o = {24'h0, b_num_i, 4'h8};
    // Data line toggles outside an ack
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_o  <= 1'b0;
            wait_r <= 2'h0;
            data_o <= 16'hA5A5;
        end else if (req_i && !ack_o && wait_r == (slow_i ? 2'h2 : 2'h0)) begin
            ack_o  <= 1'b1;
            data_o <= mem[addr_i[6:1]];
            wait_r <= 2'h0;
        end else begin
            ack_o  <= 1'b0;
            data_o <= ~data_o;
            wait_r <= (req_i && !ack_o) ? wait_r + 2'h1 : 2'h0;
        end
    end
endmodule
`default_nettype wire

/* File: test/instruction_format_decoder_tb_top.sv */
// Testbench top: decoder against the storage and register model.
// Assumes programs lie in 0x100-0x17F of the model.
`timescale 1ns/1ps
`default_nettype none
module instruction_format_decoder_tb_top;
    logic        CLK_SYS_I, RESET_I, START_I, STOP_I, EXP_EN_I, PROT_EN_I;
    logic        DEC_READY_I, MEM_ACK_I, slow;
    logic [17:0] START_ADDR_I, MEM_ADDR_O, INST_ADDR_O, EA1_O, EA2_O;
    logic [15:0] MEM_DATA_I;
    logic [31:0] REG_A_DATA_I, REG_B_DATA_I;
    logic        MEM_REQ_O, BUSY_O, DEC_VALID_O, FIRST_IS_MASK_O, IMM_VALID_O;
    logic [1:0]  ERR_O;
    logic [2:0]  FMT_O, OP_SIZE_O, INST_LEN_O;
    logic [3:0]  REG_A_NUM_O, REG_B_NUM_O, FIRST_REG_O, SECOND_REG_O;
    logic [3:0]  INDEX_REG_O, FIRST_BASE_O, SECOND_BASE_O;
    logic [11:0] FIRST_OFFSET_O, SECOND_OFFSET_O;
    logic [7:0]  OPCODE_O, IMM_DATA_O;
    logic [8:0]  OPLEN1_O, OPLEN2_O;
    int          err_total, tests_run, req_cnt;
    ifd_decoder i_ifd_decoder (.CLK_SYS_I, .RESET_I, .START_I, .START_ADDR_I, .STOP_I,
        .EXP_EN_I, .PROT_EN_I, .MEM_REQ_O, .MEM_ADDR_O, .MEM_ACK_I, .MEM_DATA_I,
        .REG_A_NUM_O, .REG_A_DATA_I, .REG_B_NUM_O, .REG_B_DATA_I, .BUSY_O, .DEC_VALID_O,
        .DEC_READY_I, .ERR_O, .INST_ADDR_O, .OPCODE_O, .FMT_O, .OP_SIZE_O, .INST_LEN_O,
        .FIRST_REG_O, .SECOND_REG_O, .INDEX_REG_O, .FIRST_BASE_O, .FIRST_OFFSET_O,
        .SECOND_BASE_O, .SECOND_OFFSET_O, .FIRST_IS_MASK_O, .IMM_VALID_O, .IMM_DATA_O,
        .OPLEN1_O, .OPLEN2_O, .EA1_O, .EA2_O);
    ifd_mem_model i_ifd_mem_model (.clk_i(CLK_SYS_I), .rst_i(RESET_I), .slow_i(slow),
        .req_i(MEM_REQ_O), .addr_i(MEM_ADDR_O), .ack_o(MEM_ACK_I), .data_o(MEM_DATA_I),
        .a_num_i(REG_A_NUM_O), .a_data_o(REG_A_DATA_I), .b_num_i(REG_B_NUM_O),
        .b_data_o(REG_B_DATA_I));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [17:0] a, input logic [15:0] hw);
        i_ifd_mem_model.mem[a[6:1]] = hw;
    endtask
    task automatic start(input logic [17:0] a);
        @(posedge CLK_SYS_I);
        START_I      <= 1'b1;
        START_ADDR_I <= a;
        @(posedge CLK_SYS_I);
        START_I      <= 1'b0;
    endtask
    task automatic wait_dec(input logic [17:0] a, input logic [2:0] f, input logic [2:0] n);
        int k;
        k = 0;
        do begin
            @(posedge CLK_SYS_I);
            #1;
            k++;
        end while (DEC_VALID_O !== 1'b1 && k < 60);
        if (DEC_VALID_O !== 1'b1) begin
            err_total++;
            report_and_stop();
        end
        chk(INST_ADDR_O, a);
        chk(FMT_O, f);
        chk(INST_LEN_O, n);
    endtask
    task automatic take(input logic s);
        @(posedge CLK_SYS_I);
        DEC_READY_I <= 1'b1;
        STOP_I      <= s;
        @(posedge CLK_SYS_I);
        DEC_READY_I <= 1'b0;
        STOP_I      <= 1'b0;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_basic();
        put(18'h100, 16'h1A23);
        put(18'h102, 16'h4112);
        put(18'h104, 16'h3010);
        put(18'h106, 16'h8615);
        put(18'h108, 16'h0123);
        put(18'h10A, 16'h92AB);
        put(18'h10C, 16'h4007);
        put(18'h10E, 16'hD2FF);
        put(18'h110, 16'h1001);
        put(18'h112, 16'h2002);
        start(18'h100);
        wait_dec(18'h100, 3'h0, 3'h2);
        chk(OPCODE_O, 18'h1A);
        chk({FIRST_REG_O, SECOND_REG_O}, 18'h23);
        chk(OP_SIZE_O, 18'h2);
        take(1'b0);
        wait_dec(18'h102, 3'h1, 3'h4);
        chk({INDEX_REG_O, SECOND_BASE_O, SECOND_OFFSET_O}, 18'h23010);
        chk(EA2_O, 18'h70);
        chk(FIRST_REG_O, 18'h1);
        take(1'b0);
        wait_dec(18'h106, 3'h2, 3'h4);
        chk({FIRST_REG_O, SECOND_REG_O}, 18'h15);
        chk(EA2_O, 18'h123);
        take(1'b0);
        wait_dec(18'h10A, 3'h3, 3'h4);
        chk({IMM_VALID_O, IMM_DATA_O}, 18'h1AB);
        chk({FIRST_BASE_O, FIRST_OFFSET_O}, 18'h4007);
        chk(EA1_O, 18'h4F);
        take(1'b0);
        wait_dec(18'h10E, 3'h4, 3'h6);
        chk({OPLEN1_O, OPLEN2_O}, {9'h100, 9'h100});
        chk({EA1_O[7:0], EA2_O[7:0]}, 18'h192A);
        take(1'b1);
    endtask
    task automatic t_expand();
        slow      <= 1'b1;
        EXP_EN_I  <= 1'b1;
        PROT_EN_I <= 1'b1;
        put(18'h120, 16'hFA30);
        put(18'h122, 16'h1001);
        put(18'h124, 16'h2002);
        put(18'h126, 16'h0A5C);
        put(18'h128, 16'h0712);
        put(18'h12A, 16'h2834);
        put(18'h12C, 16'h0812);
        start(18'h120);
        wait_dec(18'h120, 3'h4, 3'h6);
        chk({OPLEN1_O, OPLEN2_O}, {9'h4, 9'h1});
        take(1'b0);
        wait_dec(18'h126, 3'h0, 3'h2);
        chk({IMM_VALID_O, IMM_DATA_O}, 18'h15C);
        take(1'b0);
        wait_dec(18'h128, 3'h0, 3'h2);
        chk(FIRST_IS_MASK_O, 18'h1);
        take(1'b0);
        wait_dec(18'h12A, 3'h0, 3'h2);
        chk(OP_SIZE_O, 18'h3);
        take(1'b0);
        wait_dec(18'h12C, 3'h0, 3'h2);
        chk(ERR_O, 18'h0);
        take(1'b1);
    endtask
    task automatic t_errors();
        int c;
        PROT_EN_I <= 1'b0;
        put(18'h130, 16'h0812);
        start(18'h130);
        wait_dec(18'h130, 3'h0, 3'h2);
        chk(ERR_O, 18'h2);
        take(1'b0);
        #1;
        chk(BUSY_O, 18'h0);
        c = req_cnt;
        start(18'h101);
        wait_dec(18'h101, 3'h0, 3'h2);
        chk(ERR_O, 18'h1);
        chk(req_cnt - c, 18'h0);
        take(1'b0);
    endtask
    always @(posedge CLK_SYS_I) begin
        if (MEM_REQ_O === 1'b1) begin
            req_cnt++;
        end
    end
    initial begin
        CLK_SYS_I = 1'b0;
        forever #5 CLK_SYS_I = ~CLK_SYS_I;
    end
    initial begin
        {RESET_I, START_I, STOP_I, EXP_EN_I, PROT_EN_I, DEC_READY_I, slow} = 7'h40;
        START_ADDR_I = 18'h0;
        {err_total, tests_run, req_cnt} = '0;
        repeat (10) @(posedge CLK_SYS_I);
        RESET_I <= 1'b0;
        #1;
        chk({BUSY_O, DEC_VALID_O, MEM_REQ_O, INST_LEN_O}, 18'h2);
        t_basic();
        t_expand();
        t_errors();
        report_and_stop();
    end
endmodule
`default_nettype wire
